/* sws_pkg.sv */
package sws_pkg;

    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1_000;

    // Times as specified, in their own unit
    localparam int unsigned SENSE_FILT_US    = 2;
    localparam int unsigned EW_PULSE_US      = 10;
    localparam int unsigned MRST_MIN_US      = 20;
    localparam int unsigned WD_PULSE_US      = 100;
    localparam int unsigned PERIOD_SHORT_MS  = 10;
    localparam int unsigned PERIOD_MID_MS    = 100;
    localparam int unsigned PERIOD_LONG_MS   = 1000;

    // Cycle counts (least times, exact at 50 MHz)
    localparam int unsigned SENSE_FILT_CYC   = SENSE_FILT_US * CYC_PER_US;
    localparam int unsigned EW_PULSE_CYC     = EW_PULSE_US * CYC_PER_US;
    localparam int unsigned MRST_MIN_CYC     = MRST_MIN_US * CYC_PER_US;
    localparam int unsigned WD_PULSE_CYC     = WD_PULSE_US * CYC_PER_US;
    localparam int unsigned PERIOD_SHORT_CYC = PERIOD_SHORT_MS * CYC_PER_MS;
    localparam int unsigned PERIOD_MID_CYC   = PERIOD_MID_MS * CYC_PER_MS;
    localparam int unsigned PERIOD_LONG_CYC  = PERIOD_LONG_MS * CYC_PER_MS;

    localparam int unsigned CNT_W            = 26;
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned PIN_W            = 10;

    // Register map
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] MASK_ADDR   = 8'h08;
    localparam logic [ADDR_W-1:0] STATE_ADDR  = 8'h0c;

    localparam logic [31:0] CTRL_RST         = 32'h0;
    localparam logic [31:0] MASK_RST         = 32'h0;
    localparam logic        FLAG_RST         = 1'b1;
    localparam logic [PIN_W-1:0] PIN_RST     = 10'h001;

    // Control: two-bit delay select per rail, low rail first
    localparam int unsigned CTRL_DLY_LSB     = 0;
    localparam int unsigned CTRL_DLY_W       = 2;

    // Event bits, shared by status and mask
    localparam int unsigned EVT_WD           = 0;
    localparam int unsigned EVT_EW1          = 1;
    localparam int unsigned EVT_EW2          = 2;
    localparam int unsigned EVT_MRST         = 3;
    localparam int unsigned EVT_RAIL         = 4;
    localparam int unsigned EVT_W            = 5;

    // Three-level strap codes
    localparam logic [1:0] SEL_LOW           = 2'h0;
    localparam logic [1:0] SEL_FLOAT         = 2'h1;

    typedef enum logic [1:0] {
        SWS_WD_IDLE    = 2'b00,
        SWS_WD_RUN     = 2'b01,
        SWS_WD_EXPIRED = 2'b10
    } sws_wd_state_type;

endpackage

/* sws_timer.sv */
module sws_timer
    import sws_pkg::*;
#(
    parameter int unsigned W = CNT_W
) (
    input  wire logic         CLK,
    input  wire logic         RST_N,
    input  wire logic         RUN,
    input  wire logic [W-1:0] LIMIT,
    output logic      [W-1:0] COUNT,
    output logic              DONE
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } sws_timer_state_type;

    sws_timer_state_type st_r;
    sws_timer_state_type st_nxt;

    // Counts while RUN holds, saturates at LIMIT, clears when RUN drops
    always_comb begin
        st_nxt = st_r;
        if (!RUN) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt != LIMIT) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign COUNT = st_r.cnt;
    assign DONE  = RUN && (st_r.cnt == LIMIT);

endmodule // sws_timer

/* sws_supervisor.sv */
// Added by the designer: the register offsets and the strobed register port.
module sws_supervisor
    import sws_pkg::*;
#(
    parameter bit               HAS_WATCHDOG = 1'b1,
    parameter logic [CNT_W-1:0] PERIOD_SHORT = CNT_W'(PERIOD_SHORT_CYC),
    parameter logic [CNT_W-1:0] PERIOD_MID   = CNT_W'(PERIOD_MID_CYC),
    parameter logic [CNT_W-1:0] PERIOD_LONG  = CNT_W'(PERIOD_LONG_CYC),
    parameter logic [CNT_W-1:0] WD_PULSE     = CNT_W'(WD_PULSE_CYC)
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR_EN,
    input  wire logic              RD_EN,
    output logic      [31:0]       RDATA,
    output logic                   IRQ,
    input  wire logic              MASTER_MANUAL_RESET_N,
    input  wire logic              KICK_PULSE_IN,
    input  wire logic [1:0]        WATCHDOG_PERIOD_SELECT,
    input  wire logic              SENSE_INPUT_ONE_BELOW,
    input  wire logic              SENSE_INPUT_TWO_BELOW,
    input  wire logic [1:0]        RAIL_ABOVE_1V5,
    input  wire logic [1:0]        RAIL_IN_TOL,
    output logic      [1:0]        SUPPLY_RESET_N,
    output logic                   EARLY_WARNING_ONE_N,
    output logic                   EARLY_WARNING_TWO_N,
    output logic                   WATCHDOG_EXPIRED_N,
    output logic                   LAST_RESET_SOURCE_FLAG
);

    localparam logic [CNT_W-1:0] SENSE_LIM = CNT_W'(SENSE_FILT_CYC);
    localparam logic [CNT_W-1:0] EW_LIM    = CNT_W'(EW_PULSE_CYC);
    localparam logic [CNT_W-1:0] MRST_LIM  = CNT_W'(MRST_MIN_CYC);

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic             kick_d;
        logic [1:0]       tol_d;
        logic             mrst_q_d;
        logic             mrst_after;
        logic [1:0]       ew_q_d;
        logic [1:0]       ew_pulse;
        sws_wd_state_type wd;
        logic             flag;
        logic [1:0]       rst_n;
        logic [1:0]       ew_n;
        logic             wd_n;
        logic [31:0]      ctrl;
        logic [31:0]      mask;
        logic [EVT_W-1:0] status;
        logic [31:0]      rdata;
    } sws_state_type;

    sws_state_type    st_r;
    sws_state_type    st_nxt;

    logic [PIN_W-1:0] pins;
    logic             mrst_n_s;
    logic             kick_s;
    logic [1:0]       below;
    logic [1:0]       v15;
    logic [1:0]       tol;
    logic [1:0]       psel;
    logic             power_low;
    logic             kick_edge;
    logic             mrst_qual;
    logic             mrst_rise;
    logic             mrst_dly_done;
    logic             force_all;
    logic             rail_evt;
    logic             wd_done;
    logic             wdp_done;
    logic             wd_enter;
    logic [1:0]       rail_ok;
    logic [1:0]       ew_qual;
    logic [1:0]       ew_rise;
    logic [1:0]       ew_hold_done;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] wd_limit;
    logic [EVT_W-1:0] events;

    function automatic logic [CNT_W-1:0] period_of(input logic [1:0] sel);
        if (sel == SEL_LOW) begin
            return PERIOD_SHORT;
        end else if (sel == SEL_FLOAT) begin
            return PERIOD_MID;
        end
        return PERIOD_LONG;
    endfunction

    assign pins = {WATCHDOG_PERIOD_SELECT, RAIL_IN_TOL, RAIL_ABOVE_1V5,
                   SENSE_INPUT_TWO_BELOW, SENSE_INPUT_ONE_BELOW, KICK_PULSE_IN, MASTER_MANUAL_RESET_N};
    assign {psel, tol, v15, below, kick_s, mrst_n_s} = st_r.s2;

    assign power_low = ~|v15;
    assign kick_edge = kick_s ^ st_r.kick_d;
    assign mrst_rise = mrst_qual & ~st_r.mrst_q_d;
    assign force_all = power_low | mrst_qual | st_r.mrst_after;
    assign rail_evt  = |(st_r.tol_d & ~tol);
    assign wd_limit  = period_of(psel);
    assign ew_rise   = ew_qual & ~st_r.ew_q_d & {~HAS_WATCHDOG, 1'b1};
    assign wd_enter  = (st_r.wd == SWS_WD_RUN) & wd_done & (|rail_ok);

    assign events[EVT_WD]   = wd_enter;
    assign events[EVT_EW1]  = ew_rise[0];
    assign events[EVT_EW2]  = ew_rise[1];
    assign events[EVT_MRST] = mrst_rise;
    assign events[EVT_RAIL] = rail_evt;

    // Master reset qualifies after a sustained low, then holds a delay after release
    sws_timer u_mrst_filt (
        .CLK(CLK), .RST_N(RST_N), .RUN(~mrst_n_s & ~power_low), .LIMIT(MRST_LIM),
        .COUNT(), .DONE(mrst_qual)
    );
    sws_timer u_mrst_dly (
        .CLK(CLK), .RST_N(RST_N), .RUN(st_r.mrst_after & ~mrst_qual),
        .LIMIT(period_of(st_r.ctrl[CTRL_DLY_LSB +: CTRL_DLY_W])), .COUNT(), .DONE(mrst_dly_done)
    );

    for (genvar i = 0; i < 2; i++) begin : g_ch
        sws_timer u_rail (
            .CLK(CLK), .RST_N(RST_N), .RUN(tol[i] & ~power_low & ~mrst_qual),
            .LIMIT(period_of(st_r.ctrl[CTRL_DLY_LSB + CTRL_DLY_W * i +: CTRL_DLY_W])),
            .COUNT(), .DONE(rail_ok[i])
        );
        sws_timer u_filt (
            .CLK(CLK), .RST_N(RST_N), .RUN(below[i]), .LIMIT(SENSE_LIM),
            .COUNT(), .DONE(ew_qual[i])
        );
        sws_timer u_hold (
            .CLK(CLK), .RST_N(RST_N), .RUN(st_r.ew_pulse[i]), .LIMIT(EW_LIM),
            .COUNT(), .DONE(ew_hold_done[i])
        );
    end

    // A strobe edge drops RUN for one cycle, clearing the count; host keeps it frequent
    sws_timer u_wd (
        .CLK(CLK), .RST_N(RST_N), .RUN((st_r.wd == SWS_WD_RUN) & ~kick_edge),
        .LIMIT(wd_limit), .COUNT(wd_cnt), .DONE(wd_done)
    );
    sws_timer u_wd_pulse (
        .CLK(CLK), .RST_N(RST_N), .RUN(st_r.wd == SWS_WD_EXPIRED), .LIMIT(WD_PULSE),
        .COUNT(), .DONE(wdp_done)
    );

    always_comb begin
        st_nxt          = st_r;
        st_nxt.s1       = pins;
        st_nxt.s2       = st_r.s1;
        st_nxt.kick_d   = kick_s;
        st_nxt.tol_d    = tol;
        st_nxt.mrst_q_d = mrst_qual;
        st_nxt.ew_q_d   = ew_qual;
        if (mrst_qual) begin
            st_nxt.mrst_after = 1'b1;
        end else if (mrst_dly_done) begin
            st_nxt.mrst_after = 1'b0;
        end
        st_nxt.ew_pulse = (st_r.ew_pulse & ~ew_hold_done) | ew_rise;
        if (mrst_rise) begin
            st_nxt.flag = 1'b0;
        end else if (rail_evt) begin
            st_nxt.flag = 1'b1;
        end
        // No disable path: only rail state starts or stops the watchdog
        case (st_r.wd)
            SWS_WD_IDLE: begin
                if (HAS_WATCHDOG && (|rail_ok)) begin
                    st_nxt.wd = SWS_WD_RUN;
                end
            end
            SWS_WD_RUN: begin
                if (!(|rail_ok)) begin
                    st_nxt.wd = SWS_WD_IDLE;
                end else if (wd_done) begin
                    st_nxt.wd = SWS_WD_EXPIRED;
                end
            end
            SWS_WD_EXPIRED: begin
                if (wdp_done) begin
                    st_nxt.wd = (|rail_ok) ? SWS_WD_RUN : SWS_WD_IDLE;
                end
            end
            default: begin
                st_nxt.wd = SWS_WD_IDLE;
            end
        endcase
        st_nxt.rst_n   = rail_ok;
        st_nxt.ew_n[0] = ~(force_all | ew_qual[0] | st_r.ew_pulse[0]);
        if (HAS_WATCHDOG) begin
            st_nxt.ew_n[1] = ~force_all;
        end else begin
            st_nxt.ew_n[1] = ~(force_all | ew_qual[1] | st_r.ew_pulse[1]);
        end
        st_nxt.wd_n = ~(force_all | (st_nxt.wd == SWS_WD_EXPIRED));
        if (WR_EN) begin
            if (ADDR == CTRL_ADDR) begin
                st_nxt.ctrl = WDATA;
            end else if (ADDR == MASK_ADDR) begin
                st_nxt.mask = WDATA;
            end else if (ADDR == STATUS_ADDR) begin
                st_nxt.status = st_r.status & ~WDATA[EVT_W-1:0];
            end
        end
        // New events win over a same-cycle clear
        st_nxt.status = st_nxt.status | events;
        st_nxt.rdata  = '0;
        if (RD_EN) begin
            if (ADDR == CTRL_ADDR) begin
                st_nxt.rdata = st_r.ctrl;
            end else if (ADDR == STATUS_ADDR) begin
                st_nxt.rdata = 32'(st_r.status);
            end else if (ADDR == MASK_ADDR) begin
                st_nxt.rdata = st_r.mask;
            end else if (ADDR == STATE_ADDR) begin
                st_nxt.rdata = 32'({st_r.wd, power_low, st_r.rst_n, st_r.flag, st_r.ew_n, st_r.wd_n});
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r      <= '0;
            st_r.s1   <= PIN_RST;
            st_r.s2   <= PIN_RST;
            st_r.flag <= FLAG_RST;
            st_r.ctrl <= CTRL_RST;
            st_r.mask <= MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA                  = st_r.rdata;
    assign IRQ                    = |(st_r.status & st_r.mask[EVT_W-1:0]);
    assign SUPPLY_RESET_N         = st_r.rst_n;
    assign EARLY_WARNING_ONE_N    = st_r.ew_n[0];
    assign EARLY_WARNING_TWO_N    = st_r.ew_n[1];
    assign WATCHDOG_EXPIRED_N     = st_r.wd_n;
    assign LAST_RESET_SOURCE_FLAG = st_r.flag;

    // Helper run-length counters for the checks below
    logic [15:0] below_len_r;
    logic [15:0] pulse_len_r;
    logic [15:0] exp_len_r;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            below_len_r <= '0;
            pulse_len_r <= '0;
            exp_len_r   <= '0;
        end else begin
            below_len_r <= below[0] ? below_len_r + (below_len_r != 16'hffff) : '0;
            pulse_len_r <= st_r.ew_pulse[0] ? pulse_len_r + (pulse_len_r != 16'hffff) : '0;
            exp_len_r   <= (st_r.wd == SWS_WD_EXPIRED) ? exp_len_r + (exp_len_r != 16'hffff) : '0;
        end
    end

    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_flag_mrst_low: assert property (mrst_rise |=> !LAST_RESET_SOURCE_FLAG)
        else $error("source flag not low after master reset");
    a_flag_hold_high: assert property (LAST_RESET_SOURCE_FLAG && !mrst_rise |=> LAST_RESET_SOURCE_FLAG)
        else $error("source flag dropped without master reset");
    a_power_force: assert property (power_low |=> (SUPPLY_RESET_N == 2'b00) && !WATCHDOG_EXPIRED_N)
        else $error("outputs not forced while rails low");
    a_ew_pulse_len: assert property ($fell(st_r.ew_pulse[0]) |-> pulse_len_r >= EW_PULSE_CYC)
        else $error("early warning pulse too short");
    a_ew_filter: assert property (ew_qual[0] |-> below_len_r >= SENSE_FILT_CYC)
        else $error("early warning raised before filter time");
    a_ew_follow: assert property (!force_all && !ew_qual[0] && !st_r.ew_pulse[0] |=> EARLY_WARNING_ONE_N)
        else $error("early warning low without cause");
    a_ew_powerup: assert property (power_low |=> !EARLY_WARNING_ONE_N && !EARLY_WARNING_TWO_N)
        else $error("early warnings released below 1.5V");
    a_one_channel: assert property (HAS_WATCHDOG && !force_all |=> EARLY_WARNING_TWO_N)
        else $error("second channel active in watchdog variant");
    a_wd_timeout: assert property ($rose(st_r.wd == SWS_WD_EXPIRED) |-> $past(wd_cnt) == $past(wd_limit))
        else $error("watchdog expired before timeout");
    a_wd_start: assert property (!(|rail_ok) && st_r.wd != SWS_WD_EXPIRED |=> st_r.wd == SWS_WD_IDLE)
        else $error("watchdog runs with all resets active");
    a_wd_restart: assert property (kick_edge && st_r.wd == SWS_WD_RUN |=> wd_cnt == '0)
        else $error("strobe edge did not restart timeout");
    a_wd_pulse_low: assert property (st_r.wd == SWS_WD_EXPIRED |-> !WATCHDOG_EXPIRED_N)
        else $error("expiry output high during pulse");
    a_wd_pulse_len: assert property ($fell(st_r.wd == SWS_WD_EXPIRED) |-> exp_len_r >= WD_PULSE)
        else $error("expiry pulse too short");
    a_mrst_force: assert property (mrst_qual |=> SUPPLY_RESET_N == 2'b00 ##1 st_r.mrst_after)
        else $error("master reset did not force outputs");

    c_wd_expire: cover property (wd_enter);
    c_ew_pulse: cover property ($rose(st_r.ew_pulse[0]));
    c_flag_low: cover property ($fell(LAST_RESET_SOURCE_FLAG));
    c_kick: cover property (kick_edge && st_r.wd == SWS_WD_RUN);

endmodule // sws_supervisor

/* sws_host_model.sv */
module sws_host_model #(
    parameter int unsigned INTERVAL = 100
) (
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic kick_en,
    output logic      kick_out
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned cnt_r;

    // Strobe toggles well inside the shortest timeout; it stands still while disabled
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r    <= 0;
            kick_out <= 1'b0;
        end else if (!kick_en) begin
            cnt_r <= 0;
        end else if (cnt_r == INTERVAL - 1) begin
            cnt_r    <= 0;
            kick_out <= ~kick_out;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule // sws_host_model

/* tb_supervisor_status_and_watchdog.sv */
module tb_supervisor_status_and_watchdog
    import sws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned P_SHORT = 200;
    localparam int unsigned P_MID   = 400;
    localparam int unsigned P_LONG  = 800;
    localparam int unsigned P_PULSE = 50;

    logic              CLK = 1'b0;
    logic              RST_N = 1'b0;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [31:0]       WDATA = '0;
    logic              WR_EN = 1'b0;
    logic              RD_EN = 1'b0;
    logic [31:0]       RDATA;
    logic              IRQ;
    logic              MASTER_MANUAL_RESET_N = 1'b1;
    logic              KICK_PULSE_IN;
    logic [1:0]        WATCHDOG_PERIOD_SELECT = SEL_LOW;
    logic              SENSE_INPUT_ONE_BELOW = 1'b0;
    logic              SENSE_INPUT_TWO_BELOW = 1'b0;
    logic [1:0]        RAIL_ABOVE_1V5 = 2'h0;
    logic [1:0]        RAIL_IN_TOL = 2'h0;
    logic [1:0]        SUPPLY_RESET_N;
    logic              EARLY_WARNING_ONE_N;
    logic              EARLY_WARNING_TWO_N;
    logic              WATCHDOG_EXPIRED_N;
    logic              LAST_RESET_SOURCE_FLAG;
    logic              kick_en = 1'b0;
    int                error_cnt = 0;
    int                checked = 0;
    int                n;
    int unsigned       per [3] = '{P_SHORT, P_MID, P_LONG};

    always #10 CLK = ~CLK;

    sws_supervisor #(
        .HAS_WATCHDOG (1'b1),
        .PERIOD_SHORT (CNT_W'(P_SHORT)),
        .PERIOD_MID   (CNT_W'(P_MID)),
        .PERIOD_LONG  (CNT_W'(P_LONG)),
        .WD_PULSE     (CNT_W'(P_PULSE))
    ) u_dut (
        .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .RDATA(RDATA), .IRQ(IRQ), .MASTER_MANUAL_RESET_N(MASTER_MANUAL_RESET_N),
        .KICK_PULSE_IN(KICK_PULSE_IN), .WATCHDOG_PERIOD_SELECT(WATCHDOG_PERIOD_SELECT),
        .SENSE_INPUT_ONE_BELOW(SENSE_INPUT_ONE_BELOW), .SENSE_INPUT_TWO_BELOW(SENSE_INPUT_TWO_BELOW),
        .RAIL_ABOVE_1V5(RAIL_ABOVE_1V5), .RAIL_IN_TOL(RAIL_IN_TOL), .SUPPLY_RESET_N(SUPPLY_RESET_N),
        .EARLY_WARNING_ONE_N(EARLY_WARNING_ONE_N), .EARLY_WARNING_TWO_N(EARLY_WARNING_TWO_N),
        .WATCHDOG_EXPIRED_N(WATCHDOG_EXPIRED_N), .LAST_RESET_SOURCE_FLAG(LAST_RESET_SOURCE_FLAG)
    );

    sws_host_model #(.INTERVAL(100)) u_host (
        .CLK(CLK), .RST_N(RST_N), .kick_en(kick_en), .kick_out(KICK_PULSE_IN)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
        chk({31'h0, (v >= lo && v <= hi)}, 32'h1, msg);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
        @(posedge CLK);
        ADDR  <= a;
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1;
        chk(RDATA & m, exp, msg);
    endtask

    task automatic wd_expiry(input int p);
        for (n = 0; n < p + 50 && WATCHDOG_EXPIRED_N !== 1'b0; n++) @(posedge CLK);
        chk_rng(n, p - 2, p + 8, "timeout length");
        for (n = 0; n < P_PULSE + 50 && WATCHDOG_EXPIRED_N === 1'b0; n++) @(posedge CLK);
        chk_rng(n, P_PULSE, P_PULSE + 4, "expiry pulse width");
    endtask

    task automatic wait_rails;
        for (n = 0; n < 3000 && SUPPLY_RESET_N !== 2'h3; n++) @(posedge CLK);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge CLK);
        error_cnt++;
        $display("ERROR %0t: run did not finish in time", $time);
        end_of_test();
    end

    initial begin
        cyc(10);
        RST_N <= 1'b1;
        cyc(4);
        chk(32'({SUPPLY_RESET_N, EARLY_WARNING_ONE_N, EARLY_WARNING_TWO_N, WATCHDOG_EXPIRED_N}), 32'h0, "low rails");
        chk(32'(LAST_RESET_SOURCE_FLAG), 32'h1, "flag at power-on");
        reg_rd(CTRL_ADDR, 32'hffffffff, CTRL_RST, "ctrl reset value");
        reg_rd(MASK_ADDR, 32'hffffffff, MASK_RST, "mask reset value");
        reg_rd(8'h10, 32'hffffffff, 32'h0, "unmapped read");
        $display("test reset done");

        RAIL_ABOVE_1V5 <= 2'h3;
        RAIL_IN_TOL    <= 2'h3;
        for (n = 0; n < 3000 && SUPPLY_RESET_N === 2'h0; n++) @(posedge CLK);
        chk_rng(n, P_SHORT, P_SHORT + 10, "rail reset delay");
        chk(32'(EARLY_WARNING_ONE_N), 32'h1, "warning released");
        wd_expiry(P_SHORT);
        kick_en <= 1'b1;
        $display("test power_up done");

        n = 0;
        repeat (2000) begin
            @(posedge CLK);
            if (WATCHDOG_EXPIRED_N !== 1'b1) n++;
        end
        chk(n, 0, "kicked watchdog expired");
        $display("test kicked done");

        for (int s = 0; s < 3; s++) begin
            WATCHDOG_PERIOD_SELECT <= 2'(s);
            cyc(10);
            @(KICK_PULSE_IN);
            kick_en <= 1'b0;
            wd_expiry(per[s]);
            kick_en <= 1'b1;
        end
        reg_rd(STATUS_ADDR, 32'h1, 32'h1, "expiry status");
        chk(32'(IRQ), 32'h0, "masked irq");
        reg_wr(MASK_ADDR, 32'h1);
        #1;
        chk(32'(IRQ), 32'h1, "unmasked irq");
        reg_wr(STATUS_ADDR, 32'h1);
        #1;
        chk(32'(IRQ), 32'h0, "cleared irq");
        $display("test periods done");

        SENSE_INPUT_ONE_BELOW <= 1'b1;
        cyc(50);
        SENSE_INPUT_ONE_BELOW <= 1'b0;
        for (n = 0; n < 200 && EARLY_WARNING_ONE_N === 1'b1; n++) @(posedge CLK);
        chk(n, 200, "short dip filtered");
        SENSE_INPUT_ONE_BELOW <= 1'b1;
        for (n = 0; n < 200 && EARLY_WARNING_ONE_N === 1'b1; n++) @(posedge CLK);
        chk_rng(n, SENSE_FILT_CYC, SENSE_FILT_CYC + 8, "filter delay");
        SENSE_INPUT_ONE_BELOW <= 1'b0;
        for (n = 0; n < 1000 && EARLY_WARNING_ONE_N === 1'b0; n++) @(posedge CLK);
        chk_rng(n, EW_PULSE_CYC, EW_PULSE_CYC + 10, "warning pulse");
        SENSE_INPUT_ONE_BELOW <= 1'b1;
        cyc(120);
        n = 0;
        repeat (700) begin
            @(posedge CLK);
            if (EARLY_WARNING_ONE_N !== 1'b0) n++;
        end
        chk(n, 0, "warning held while below");
        SENSE_INPUT_ONE_BELOW <= 1'b0;
        for (n = 0; n < 50 && EARLY_WARNING_ONE_N === 1'b0; n++) @(posedge CLK);
        chk_rng(n, 0, 8, "warning release");
        SENSE_INPUT_TWO_BELOW <= 1'b1;
        n = 0;
        repeat (300) begin
            @(posedge CLK);
            if (EARLY_WARNING_TWO_N !== 1'b1) n++;
        end
        chk(n, 0, "second channel absent");
        SENSE_INPUT_TWO_BELOW <= 1'b0;
        $display("test sense done");

        MASTER_MANUAL_RESET_N <= 1'b0;
        for (n = 0; n < 1200 && LAST_RESET_SOURCE_FLAG === 1'b1; n++) @(posedge CLK);
        chk_rng(n, MRST_MIN_CYC, MRST_MIN_CYC + 8, "master reset qualify");
        cyc(2);
        chk(32'({SUPPLY_RESET_N, EARLY_WARNING_ONE_N, WATCHDOG_EXPIRED_N}), 32'h0, "master forcing");
        cyc(20);
        MASTER_MANUAL_RESET_N <= 1'b1;
        wait_rails();
        chk(32'(SUPPLY_RESET_N), 32'h3, "rails after master reset");
        chk(32'(LAST_RESET_SOURCE_FLAG), 32'h0, "flag kept low");
        reg_rd(STATUS_ADDR, 32'h8, 32'h8, "master reset status");
        RAIL_IN_TOL <= 2'h2;
        cyc(10);
        RAIL_IN_TOL <= 2'h3;
        cyc(10);
        chk(32'(LAST_RESET_SOURCE_FLAG), 32'h1, "flag set by rail event");
        wait_rails();
        cyc(50);
        chk(32'(LAST_RESET_SOURCE_FLAG), 32'h1, "flag stays high");
        $display("test master_reset done");

        // High rail gets the middle delay code, low rail keeps the short one
        reg_wr(CTRL_ADDR, 32'h4);
        reg_rd(CTRL_ADDR, 32'hffffffff, 32'h4, "ctrl readback");
        RAIL_ABOVE_1V5 <= 2'h0;
        cyc(6);
        chk(32'({SUPPLY_RESET_N, EARLY_WARNING_ONE_N, EARLY_WARNING_TWO_N, WATCHDOG_EXPIRED_N}), 32'h0, "power low");
        RAIL_ABOVE_1V5 <= 2'h3;
        for (n = 0; n < 3000 && SUPPLY_RESET_N[1] === 1'b0; n++) @(posedge CLK);
        chk_rng(n, P_MID, P_MID + 10, "high rail delay select");
        reg_rd(STATE_ADDR, 32'h1ff, 32'hbf, "state after power return");
        $display("test power_low done");
        end_of_test();
    end
endmodule // tb_supervisor_status_and_watchdog
